// [design/led_gpo_fault_mask_regs.sv]
/*
 * Register bank for the lamp matrix driver, the plain output mode of the
 * row and column pins, and the enable mask and sticky behaviour of the
 * active-low field fault output.
 * Assumes a same-clock register port from the serial host framing logic,
 * live fault sources and the supply monitor arriving asynchronously, and
 * latched fault bits plus their read strobe from the same clock domain.
 */
`timescale 1ns/1ps

// Overview of operation
// RQ1: Matrix register bits light lamps; bits map row 0, row 1, then row 2 columns 0-1.
// RQ2: Lamp matrix is scanned so each lamp sees one third duty cycle.
// RQ3: Row 2 column 2 lamp lit while field supply is above missing threshold.
// RQ4: Non-sticky mode: fault output follows OR of live unmasked fault sources.
// RQ5: Sticky mode: any unmasked latched fault holds output low until fault register read.
// RQ6: Direction bit 0 selects lamp driving; 1 selects plain outputs from bits 5-0.
// RQ7: Plain outputs: bits 5-3 drive rows 2-0, bits 2-0 drive columns 2-0.
// RQ8: Each enable mask bit lets its fault source assert the fault output.
// RQ9: Enable mask resets to 0xc0: only CRC error and power-on sources enabled.
// RQ10: Dummy register writes change nothing; input data still shifts out meanwhile.
// RQ11: Matrix register resets to zero, all software lamps off.
// RQ12: Output register resets to zero: lamp mode, non-sticky, plain levels low.
// RQ13: Second group flag is set when any enabled second-group source is high.
// RQ14: Scanning activates one row at a time in rotation, columns from that row.
module led_gpo_fault_mask_regs (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Register port from host framing
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Live fault sources, asynchronous
  input  wire logic [7:0] fault_live_i,
  input  wire logic [5:0] second_group_src_i,
  input  wire logic       supply_missing_flag_i,
  // Second group enables and latched fault bits, same clock
  input  wire logic [5:0] second_group_en_i,
  input  wire logic [7:0] first_fault_register_i,
  input  wire logic       first_fault_read_i,
  // Field pins
  output logic      [2:0] row_pin_o,
  output logic      [2:0] column_pin_o,
  output logic            field_fault_out_n_o,
  // Internal state shown to host framing
  output logic            second_group_flag_o
);

  // ************************************************************
  // Registers and local signals
  // ************************************************************
  logic [7:0] lamp_matrix_control_reg;
  logic [7:0] pin_output_and_fault_mode_reg;
  logic [7:0] fault_output_enable_mask_reg;
  logic [7:0] rdata_reg;
  logic       sticky_hold_reg;
  logic       fault_out_n_reg;
  logic [2:0] row_pin_reg;
  logic [2:0] column_pin_reg;
  logic       second_group_flag_reg;

  logic [7:0] live_meta_reg;
  logic [7:0] live_sync_reg;
  logic [5:0] grp_meta_reg;
  logic [5:0] grp_sync_reg;
  logic       miss_meta_reg;
  logic       miss_sync_reg;

  logic [7:0] live_vector;
  logic       live_masked_any;
  logic       latched_masked_any;
  logic       sticky_fault_select;
  logic       pin_direction;
  logic       fault_out_n_next;
  logic [8:0] lamp_bits;

  lamp_scan_if scan ();

  // Masked OR, used for live and latched fault vectors
  function automatic logic masked_any(input logic [7:0] bits, input logic [7:0] mask);
    masked_any = |(bits & mask);
  endfunction

  // Address match of a write
  function automatic logic wr_hit(input logic [7:0] addr, input logic wr, input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // ************************************************************
  // Synchronisers for asynchronous inputs
  // ************************************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      live_meta_reg <= 8'h00;
      live_sync_reg <= 8'h00;
      grp_meta_reg  <= 6'h00;
      grp_sync_reg  <= 6'h00;
      miss_meta_reg <= 1'b1;
      miss_sync_reg <= 1'b1;
    end else begin
      live_meta_reg <= fault_live_i;
      live_sync_reg <= live_meta_reg;
      grp_meta_reg  <= second_group_src_i;
      grp_sync_reg  <= grp_meta_reg;
      miss_meta_reg <= supply_missing_flag_i;
      miss_sync_reg <= miss_meta_reg;
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************

  // Lamp matrix control
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lamp_matrix_control_reg <= lamp_fault_pkg::LAMP_MATRIX_CONTROL_RESET; // RQ11
    end else if (wr_hit(reg_addr_i, reg_wr_i, lamp_fault_pkg::LAMP_MATRIX_CONTROL_ADDR)) begin
      lamp_matrix_control_reg <= reg_wdata_i; // RQ1
    end
  end

  // Pin output and fault mode
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_output_and_fault_mode_reg <= lamp_fault_pkg::PIN_OUTPUT_AND_FAULT_MODE_RESET; // RQ12
    end else if (wr_hit(reg_addr_i, reg_wr_i, lamp_fault_pkg::PIN_OUTPUT_AND_FAULT_MODE_ADDR)) begin
      pin_output_and_fault_mode_reg <= reg_wdata_i;
    end
  end

  // Fault output enable mask
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_output_enable_mask_reg <= lamp_fault_pkg::FAULT_OUTPUT_ENABLE_MASK_RESET; // RQ9
    end else if (wr_hit(reg_addr_i, reg_wr_i, lamp_fault_pkg::FAULT_OUTPUT_ENABLE_MASK_ADDR)) begin
      fault_output_enable_mask_reg <= reg_wdata_i; // RQ8
    end
  end
  // Dummy chain register has no storage; a write there matches no process. RQ10

  // ************************************************************
  // Register reads
  // ************************************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= lamp_fault_pkg::UNMAPPED_READ_VALUE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        lamp_fault_pkg::LAMP_MATRIX_CONTROL_ADDR:       rdata_reg <= lamp_matrix_control_reg;
        lamp_fault_pkg::PIN_OUTPUT_AND_FAULT_MODE_ADDR: rdata_reg <= pin_output_and_fault_mode_reg;
        lamp_fault_pkg::FAULT_OUTPUT_ENABLE_MASK_ADDR:  rdata_reg <= fault_output_enable_mask_reg;
        default:                                        rdata_reg <= lamp_fault_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  // ************************************************************
  // Fault sources and second group flag
  // ************************************************************

  // Second group flag from enabled second-group sources
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      second_group_flag_reg <= 1'b0;
    end else begin
      second_group_flag_reg <= |(grp_sync_reg & second_group_en_i); // RQ13
    end
  end

  // Live vector with the second group flag in its slot
  always_comb begin
    live_vector = live_sync_reg;
    live_vector[lamp_fault_pkg::SECOND_GROUP_FLAG_BIT] = second_group_flag_reg; // RQ13
  end

  assign sticky_fault_select = pin_output_and_fault_mode_reg[lamp_fault_pkg::STICKY_FAULT_SELECT_BIT];
  assign pin_direction       = pin_output_and_fault_mode_reg[lamp_fault_pkg::PIN_DIRECTION_BIT];
  assign live_masked_any     = masked_any(live_vector, fault_output_enable_mask_reg); // RQ8
  assign latched_masked_any  = masked_any(first_fault_register_i, fault_output_enable_mask_reg); // RQ8

  // ************************************************************
  // Fault output
  // ************************************************************

  // Sticky hold; the fault register read releases it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sticky_hold_reg <= 1'b0;
    end else if (!sticky_fault_select || first_fault_read_i) begin
      sticky_hold_reg <= 1'b0; // RQ5
    end else if (latched_masked_any) begin
      sticky_hold_reg <= 1'b1; // RQ5
    end
  end

  // Output level by mode
  always_comb begin
    if (sticky_fault_select) begin
      fault_out_n_next = !(sticky_hold_reg || (latched_masked_any && !first_fault_read_i)); // RQ5
    end else begin
      fault_out_n_next = !live_masked_any; // RQ4
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_out_n_reg <= 1'b1;
    end else begin
      fault_out_n_reg <= fault_out_n_next;
    end
  end

  // ************************************************************
  // Lamp matrix and plain outputs
  // ************************************************************

  // Software lamps plus supply status lamp at row 2 column 2
  assign lamp_bits = {!miss_sync_reg, lamp_matrix_control_reg}; // RQ3

  lamp_matrix_scanner u_scanner (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .lamp_bits_i (lamp_bits),
    .scan        (scan.scanner)
  );

  // Pin drive: rows high when active, columns low to sink a lit lamp
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      row_pin_reg    <= 3'h0;
      column_pin_reg <= 3'h7;
    end else if (pin_direction) begin
      row_pin_reg    <= pin_output_and_fault_mode_reg[lamp_fault_pkg::PLAIN_ROW_LSB +: 3]; // RQ7
      column_pin_reg <= pin_output_and_fault_mode_reg[lamp_fault_pkg::PLAIN_COL_LSB +: 3]; // RQ6
    end else begin
      row_pin_reg    <= scan.row_on; // RQ2
      column_pin_reg <= ~scan.col_lit; // RQ1
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata_o         = rdata_reg;
  assign row_pin_o           = row_pin_reg;
  assign column_pin_o        = column_pin_reg;
  assign field_fault_out_n_o = fault_out_n_reg;
  assign second_group_flag_o = second_group_flag_reg;

endmodule

// [design/lamp_fault_pkg.sv]
/*
 * Constants for the lamp matrix, plain output and fault output register bank.
 * Assumes nothing beyond a SystemVerilog package scope.
 */
package lamp_fault_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] LAMP_MATRIX_CONTROL_ADDR       = 8'h20;
  localparam logic [7:0] PIN_OUTPUT_AND_FAULT_MODE_ADDR = 8'h22;
  localparam logic [7:0] FAULT_OUTPUT_ENABLE_MASK_ADDR  = 8'h24;
  localparam logic [7:0] DUMMY_CHAIN_REGISTER_ADDR      = 8'h26;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [7:0] LAMP_MATRIX_CONTROL_RESET       = 8'h00;
  localparam logic [7:0] PIN_OUTPUT_AND_FAULT_MODE_RESET = 8'h00;
  localparam logic [7:0] FAULT_OUTPUT_ENABLE_MASK_RESET  = 8'hc0;
  localparam logic [7:0] UNMAPPED_READ_VALUE             = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int STICKY_FAULT_SELECT_BIT = 7;
  localparam int PIN_DIRECTION_BIT       = 6;
  localparam int PLAIN_ROW_LSB           = 3;
  localparam int PLAIN_COL_LSB           = 0;
  localparam int SECOND_GROUP_FLAG_BIT   = 5;
  localparam int SECOND_GROUP_WIDTH      = 6;

  // ************************************************************
  // Scan timing
  // ************************************************************
  localparam int CLOCK_MHZ          = 125;
  localparam int ROW_DWELL_TIME_US  = 1;
  localparam int ROW_DWELL_CYCLES   = ROW_DWELL_TIME_US * CLOCK_MHZ;
  localparam int ROW_COUNT          = 3;

  // ************************************************************
  // Scan states, one per active row
  // ************************************************************
  typedef enum logic [1:0] {
    SCAN_ROW0,
    SCAN_ROW1,
    SCAN_ROW2
  } scan_state_t;

endpackage

// [design/lamp_scan_if.sv]
/*
 * Carrier between the register bank and the matrix scanner: the active row
 * and the lit columns for that row.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface lamp_scan_if;
  logic [2:0] row_on;
  logic [2:0] col_lit;

  // Scanner drives, bank reads
  modport scanner (output row_on, output col_lit);
  modport user    (input  row_on, input  col_lit);
endinterface

// [design/lamp_matrix_scanner.sv]
/*
 * Time-multiplexed scanner for the 3x3 lamp matrix. One row at a time is
 * active for a fixed dwell, in the order 0, 1, 2.
 * Assumes lamp_bits_i is synchronous to clock_i.
 */
`timescale 1ns/1ps
module lamp_matrix_scanner (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Lamp states, row-major, bit 8 is row 2 column 2
  input  wire logic [8:0] lamp_bits_i,
  // Row and column drive
  lamp_scan_if.scanner    scan
);

  localparam logic [7:0] DWELL_LAST = 8'(lamp_fault_pkg::ROW_DWELL_CYCLES - 1);

  lamp_fault_pkg::scan_state_t state_reg;
  logic [7:0]                  dwell_reg;

  // Dwell counter per row
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dwell_reg <= 8'h00;
    end else if (dwell_reg == DWELL_LAST) begin
      dwell_reg <= 8'h00;
    end else begin
      dwell_reg <= dwell_reg + 8'h01;
    end
  end

  // Fixed row rotation
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= lamp_fault_pkg::SCAN_ROW0;
    end else if (dwell_reg == DWELL_LAST) begin
      case (state_reg)
        lamp_fault_pkg::SCAN_ROW0: state_reg <= lamp_fault_pkg::SCAN_ROW1; // RQ14
        lamp_fault_pkg::SCAN_ROW1: state_reg <= lamp_fault_pkg::SCAN_ROW2; // RQ14
        default:                   state_reg <= lamp_fault_pkg::SCAN_ROW0; // RQ2
      endcase
    end
  end

  // Active row and its column bits
  always_comb begin
    case (state_reg)
      lamp_fault_pkg::SCAN_ROW0: begin
        scan.row_on  = 3'h1;
        scan.col_lit = lamp_bits_i[2:0]; // RQ14
      end
      lamp_fault_pkg::SCAN_ROW1: begin
        scan.row_on  = 3'h2;
        scan.col_lit = lamp_bits_i[5:3]; // RQ14
      end
      default: begin
        scan.row_on  = 3'h4;
        scan.col_lit = lamp_bits_i[8:6]; // RQ14
      end
    endcase
  end

endmodule

// [test/field_side_model.sv]
/* Far side model: latches the fault sources into the first fault register
   and reloads it with the present sources when the host reads it. Assumes one clock with the bank. */
`timescale 1ns/1ps
module field_side_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Sources and read strobe
  input  wire logic [7:0] fault_live_i,
  input  wire logic       group_flag_i,
  input  wire logic       read_i,
  // Latched fault bits
  output logic      [7:0] fault_reg_o
);
  wire [7:0] src = {fault_live_i[7:6], group_flag_i, fault_live_i[4:0]};
  // Sticky latch, read clears what was shown
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i)
      fault_reg_o <= 8'h00;
    else if (read_i)
      fault_reg_o <= src;
    else
      fault_reg_o <= fault_reg_o | src;
  end
endmodule

// [test/lamp_fault_monitor.sv]
/* Checker for the lamp, plain output and fault output bank.
   Bound to the top module, sees its ports only. */
`timescale 1ns/1ps
module lamp_fault_monitor (
  // Clock, reset, register port
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Fault side
  input wire logic [7:0] fault_live_i,
  input wire logic [5:0] second_group_src_i,
  input wire logic       supply_missing_flag_i,
  input wire logic [5:0] second_group_en_i,
  input wire logic [7:0] first_fault_register_i,
  input wire logic       first_fault_read_i,
  // Pins
  input wire logic [2:0] row_pin_o,
  input wire logic [2:0] column_pin_o,
  input wire logic       field_fault_out_n_o,
  input wire logic       second_group_flag_o
);
  logic [7:0]  lamp_q, gpo_q, mask_q, rd_exp;
  logic [44:0] snap_q;
  logic [3:0]  quiet;
  logic [9:0]  lamp_cnt, held;
  logic [2:0]  row_q, exp_col;
  wire  [44:0] snap = {fault_live_i, second_group_src_i, supply_missing_flag_i, second_group_en_i,
                       lamp_q, gpo_q, mask_q};
  // Settled count, zero in the very cycle a watched input or shadow moves
  wire  [3:0]  calm = (snap == snap_q) ? quiet : 4'h0;
  wire         lamp_ok = lamp_cnt > 10'd5 && calm > 4'd5;
  // Shadow of the writable registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lamp_q <= lamp_fault_pkg::LAMP_MATRIX_CONTROL_RESET;
      gpo_q  <= lamp_fault_pkg::PIN_OUTPUT_AND_FAULT_MODE_RESET;
      mask_q <= lamp_fault_pkg::FAULT_OUTPUT_ENABLE_MASK_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h20) lamp_q <= reg_wdata_i;
      if (reg_addr_i == 8'h22) gpo_q <= reg_wdata_i;
      if (reg_addr_i == 8'h24) mask_q <= reg_wdata_i;
    end
  end
  // Settling and dwell counters
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      snap_q   <= '0;
      quiet    <= '0;
      lamp_cnt <= '0;
      held     <= '0;
      row_q    <= '0;
    end else begin
      snap_q   <= snap;
      quiet    <= (snap != snap_q) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
      lamp_cnt <= gpo_q[6] ? 10'h0 : ((lamp_cnt == 10'h3ff) ? lamp_cnt : lamp_cnt + 10'h1);
      row_q    <= row_pin_o;
      held     <= (row_pin_o != row_q) ? 10'h1 : held + 10'h1;
    end
  end
  // Expected read data and lamp columns
  always_comb begin
    case (reg_addr_i)
      8'h20:   rd_exp = lamp_q;
      8'h22:   rd_exp = gpo_q;
      8'h24:   rd_exp = mask_q;
      default: rd_exp = 8'h00;
    endcase
    case (row_pin_o)
      3'b001:  exp_col = ~lamp_q[2:0];
      3'b010:  exp_col = ~lamp_q[5:3];
      default: exp_col = {supply_missing_flag_i, ~lamp_q[7:6]};
    endcase
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ************************************************************
  // Assertions
  // ************************************************************
  AST_READ_DATA: assert property (reg_rd_i |=> reg_rdata_o == $past(rd_exp))
    else $error("read data differs from register contents");
  AST_ROW_ROTATE: assert property (lamp_ok && row_pin_o != row_q |-> row_pin_o == {row_q[1:0], row_q[2]})
    else $error("row pins left the rotation");
  AST_ROW_DWELL: assert property (lamp_cnt > 10'd400 && row_pin_o != row_q |-> held == 10'd125)
    else $error("row dwell is not one third of the scan");
  AST_LAMP_COLS: assert property (lamp_ok |-> $onehot(row_pin_o) && column_pin_o == exp_col)
    else $error("lamp columns do not match the active row");
  AST_PLAIN_PINS: assert property (gpo_q[6] && calm > 4'd2 |-> {row_pin_o, column_pin_o} == gpo_q[5:0])
    else $error("plain output pins differ from register");
  AST_LIVE_FAULT: assert property (!gpo_q[7] && calm > 4'd5 |-> field_fault_out_n_o ==
      !(|(fault_live_i & mask_q & 8'hdf) || (mask_q[5] && second_group_flag_o)))
    else $error("fault output differs from masked live sources");
  AST_GROUP_FLAG: assert property (calm > 4'd5 |-> second_group_flag_o == |(second_group_src_i & second_group_en_i))
    else $error("second group flag wrong");
  AST_STICKY_SET: assert property (gpo_q[7] && quiet > 4'd1 && !first_fault_read_i &&
      |(first_fault_register_i & mask_q) |=> !field_fault_out_n_o)
    else $error("sticky fault output not low");
  AST_STICKY_FREE: assert property (gpo_q[7] && first_fault_read_i ##1
      (!first_fault_read_i && !(|(first_fault_register_i & mask_q)))[*3] |-> field_fault_out_n_o)
    else $error("sticky fault output not released after read");
  CVR_ROW_CHANGE: cover property (lamp_cnt > 10'd400 && row_pin_o != row_q);
  CVR_PLAIN: cover property (gpo_q[6] && quiet > 4'd2);
  CVR_STICKY: cover property (gpo_q[7] && !field_fault_out_n_o ##1 first_fault_read_i);
endmodule
bind led_gpo_fault_mask_regs lamp_fault_monitor u_lamp_fault_monitor (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fault_live_i(fault_live_i),
  .second_group_src_i(second_group_src_i), .supply_missing_flag_i(supply_missing_flag_i),
  .second_group_en_i(second_group_en_i), .first_fault_register_i(first_fault_register_i),
  .first_fault_read_i(first_fault_read_i), .row_pin_o(row_pin_o), .column_pin_o(column_pin_o),
  .field_fault_out_n_o(field_fault_out_n_o), .second_group_flag_o(second_group_flag_o));

// [test/tb.sv]
/* Self-checking bench for the lamp and fault register bank.
   Assumes the bank, its carrier interface and the far side model. */
`timescale 1ns/1ps
module tb;
  logic       clock_i, reset_n_i, reg_wr_i, reg_rd_i, supply_missing_flag_i, first_fault_read_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, fault_live_i, first_fault_register_i;
  logic [5:0] second_group_src_i, second_group_en_i;
  logic [2:0] row_pin_o, column_pin_o;
  logic       field_fault_out_n_o, second_group_flag_o;
  int         errors, cmp_count;
  led_gpo_fault_mask_regs u_led_gpo_fault_mask_regs (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fault_live_i(fault_live_i), .second_group_src_i(second_group_src_i),
    .supply_missing_flag_i(supply_missing_flag_i), .second_group_en_i(second_group_en_i),
    .first_fault_register_i(first_fault_register_i), .first_fault_read_i(first_fault_read_i),
    .row_pin_o(row_pin_o), .column_pin_o(column_pin_o), .field_fault_out_n_o(field_fault_out_n_o),
    .second_group_flag_o(second_group_flag_o));
  field_side_model u_field_side_model (.clock_i(clock_i), .reset_n_i(reset_n_i), .fault_live_i(fault_live_i),
    .group_flag_i(second_group_flag_o), .read_i(first_fault_read_i), .fault_reg_o(first_fault_register_i));
  // Step to just after the n-th rising edge from now
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    cyc(1);
    chk(reg_rdata_o, exp);
  endtask
  task automatic t_regs();
    rd(8'h20, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h24, 8'hc0);
    wr(8'h20, 8'h5a);
    wr(8'h24, 8'h3c);
    wr(8'h26, 8'hff);
    rd(8'h20, 8'h5a);
    rd(8'h24, 8'h3c);
    rd(8'h26, 8'h00);
    rd(8'h30, 8'h00);
    $display("t_regs done");
  endtask
  // Wait for a fresh window of row r, check columns and dwell
  task automatic row_win(input logic [2:0] r, input logic [2:0] c);
    int n;
    for (n = 0; n < 400 && row_pin_o === r; n++) cyc(1);
    for (n = 0; n < 400 && row_pin_o !== r; n++) cyc(1);
    chk({5'h0, column_pin_o}, {5'h0, c});
    for (n = 0; n < 400 && row_pin_o === r; n++) cyc(1);
    chk(8'(n), 8'h7d);
  endtask
  task automatic t_lamp();
    wr(8'h20, 8'ha5);
    row_win(3'b001, 3'b010);
    row_win(3'b010, 3'b011);
    row_win(3'b100, 3'b001);
    supply_missing_flag_i = 1'b1;
    row_win(3'b100, 3'b101);
    $display("t_lamp done");
  endtask
  task automatic t_plain();
    wr(8'h22, 8'h6a);
    cyc(3);
    chk({2'h0, row_pin_o, column_pin_o}, 8'h2a);
    wr(8'h22, 8'h55);
    cyc(3);
    chk({2'h0, row_pin_o, column_pin_o}, 8'h15);
    wr(8'h22, 8'h00);
    $display("t_plain done");
  endtask
  task automatic t_live();
    for (int i = 0; i < 8; i++) begin
      if (i == 5) continue;
      wr(8'h24, 8'h00);
      fault_live_i = 8'(8'h01 << i);
      cyc(6);
      chk({7'h0, field_fault_out_n_o}, 8'h01);
      wr(8'h24, 8'(8'h01 << i));
      cyc(6);
      chk({7'h0, field_fault_out_n_o}, 8'h00);
      fault_live_i = 8'h00;
      cyc(6);
      chk({7'h0, field_fault_out_n_o}, 8'h01);
    end
    wr(8'h24, 8'h20);
    for (int j = 0; j < 6; j++) begin
      second_group_src_i = 6'(6'h01 << j);
      cyc(6);
      chk({7'h0, second_group_flag_o}, 8'h00);
      second_group_en_i = 6'(6'h01 << j);
      cyc(6);
      chk({6'h0, second_group_flag_o, field_fault_out_n_o}, 8'h02);
      second_group_en_i = 6'h00;
    end
    second_group_src_i = 6'h00;
    $display("t_live done");
  endtask
  task automatic t_sticky();
    wr(8'h24, 8'hc0);
    wr(8'h22, 8'h80);
    first_fault_read_i = 1'b1;
    cyc(1);
    first_fault_read_i = 1'b0;
    cyc(4);
    chk({7'h0, field_fault_out_n_o}, 8'h01);
    fault_live_i = 8'h80;
    cyc(4);
    fault_live_i = 8'h00;
    cyc(8);
    chk({7'h0, field_fault_out_n_o}, 8'h00);
    first_fault_read_i = 1'b1;
    cyc(1);
    first_fault_read_i = 1'b0;
    cyc(4);
    chk({7'h0, field_fault_out_n_o}, 8'h01);
    $display("t_sticky done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Main sequence
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, supply_missing_flag_i, first_fault_read_i} = 5'h00;
    {reg_addr_i, reg_wdata_i, fault_live_i} = 24'h000000;
    {second_group_src_i, second_group_en_i} = 12'h000;
    repeat (16) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    cyc(1);
    t_regs();
    t_lamp();
    t_plain();
    t_live();
    t_sticky();
    stop_test();
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule
